// File: hw/fpd_decoder.sv
// Flow pulse input decoder with APB registers
//
// Contract
// R1 - Uni mode counts each closing edge
// R2 - Two-pin modes claim the even pin
// R3 - Even pin gives direction, odd counts
// R4 - Fwd/rev mode: odd pin counts forward
// R5 - Fwd/rev mode: even pin counts reverse
// R6 - Gray 00-01-11-10 steps count forward
// R7 - Gray 00-10-11-01 steps count reverse
// R8 - Quadrature allows net storage only
// R9 - Pulse-direction allows net or independent
// R10 - Fwd/rev mode allows net only
// R11 - Net keeps two counters, one set
// R12 - Independent records forward and reverse sets
// R13 - Counts taken and restarted each period
// R14 - Forward set goes to odd channel
// R15 - Reverse set to next even, read-only
// R16 - Power-save rate catches 500 ms pulses
// R17 - High-speed rate catches 16 ms pulses
// R18 - One sample rate for all channels
// R19 - Replication copies meter pulses out
// R20 - One output uni, two bi-directional
// R21 - Sample compare; skip double quadrature changes
// R22 - Net is forward minus reverse, signed
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fpd_decoder #(
  // Sample divider lengths in clock cycles; defaults sample every 8 ms and 250 ms, for 16 ms and 500 ms pulses
  parameter int unsigned HS_CYC = fpd_pkg::HS_TICK_CYC,
  parameter int unsigned PS_CYC = fpd_pkg::PS_TICK_CYC
) (
  // Clock, enable, reset
  input wire logic CLK_I,
  input wire logic CE_I,
  input wire logic ARST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Meter pulse pin pair
  input wire logic PIN_ODD_I,
  input wire logic PIN_EVEN_I,
  // Log period boundary strobe
  input wire logic LOG_TICK_I,
  // Recorded datapoints
  output logic REC_VALID_O,
  output logic REC_INDEP_O,
  output logic [fpd_pkg::CNT_W-1:0] REC_FWD_O,
  output logic [fpd_pkg::CNT_W-1:0] REC_REV_O,
  output logic [fpd_pkg::NET_W-1:0] REC_NET_O,
  // Status output replication and even pin claim
  output logic STAT_OUT1_O,
  output logic STAT_OUT2_O,
  output logic EVEN_CLAIMED_O
);
  import fpd_pkg::*;

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  fpd_mode_t mode;
  logic indep;
  logic pin_sel;
  logic tick;
  logic odd_lvl;
  logic odd_rise;
  logic even_lvl;
  logic even_rise;
  logic uni_rise;
  logic fwd_inc;
  logic rev_inc;
  logic [1:0] q_prev_r;
  logic [1:0] q_now;
  logic q_fwd;
  logic q_rev;
  logic [CNT_W-1:0] fwd_cnt_r;
  logic [CNT_W-1:0] rev_cnt_r;
  logic log_evt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign mode = fpd_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign pin_sel = ctrl_r[CTRL_PIN_BIT];
  // Independent storage only stands for pulses plus direction
  assign indep = ctrl_r[CTRL_STORE_BIT] && (mode == FPD_PDIR); // R8 R9 R10
  assign EVEN_CLAIMED_O = (mode != FPD_UNI); // R2

  // Control value written by software; storage bit forced off where not allowed
  always_comb begin
    ctrl_nxt = PWDATA_I[7:0];
    if (PWDATA_I[CTRL_MODE_LSB +: 2] != FPD_PDIR) begin
      ctrl_nxt[CTRL_STORE_BIT] = 1'b0; // R8 R10
    end
  end

  // Global sample strobe, rates derived from minimum pulse widths
  fpd_tick #(
    .HS_CYC(TICK_W'(HS_CYC)),
    .PS_CYC(TICK_W'(PS_CYC))
  ) u_tick (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .ce_i(CE_I),
    .psave_i(ctrl_r[CTRL_RATE_BIT]), // R16 R17 R18
    .tick_o(tick)
  );

  // Odd pin sampler
  fpd_edge u_odd (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .ce_i(CE_I),
    .tick_i(tick),
    .pin_i(PIN_ODD_I),
    .level_o(odd_lvl),
    .rise_o(odd_rise)
  );

  // Even pin sampler
  fpd_edge u_even (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .ce_i(CE_I),
    .tick_i(tick),
    .pin_i(PIN_EVEN_I),
    .level_o(even_lvl),
    .rise_o(even_rise)
  );

  // Quadrature state history, updated on each sample
  assign q_now = {PIN_ODD_I, PIN_EVEN_I};
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q_prev_r <= 2'h0;
    end else if (CE_I && tick) begin
      q_prev_r <= q_now; // R21
    end
  end

  // Gray step direction; a double-bit change matches neither case
  always_comb begin
    q_fwd = 1'b0;
    q_rev = 1'b0;
    unique case ({q_prev_r, q_now})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: q_fwd = 1'b1; // R6
      4'b0010, 4'b1011, 4'b1101, 4'b0100: q_rev = 1'b1; // R7
      default: begin
        q_fwd = 1'b0; // R21
        q_rev = 1'b0;
      end
    endcase
  end

  // Uni mode may use either pin of the pair
  assign uni_rise = pin_sel ? even_rise : odd_rise;

  // Increment selection per pin configuration
  always_comb begin
    fwd_inc = 1'b0;
    rev_inc = 1'b0;
    unique case (mode)
      FPD_UNI: fwd_inc = uni_rise; // R1
      FPD_PDIR: begin
        fwd_inc = odd_rise & even_lvl; // R3
        rev_inc = odd_rise & ~even_lvl; // R3
      end
      FPD_FWDREV: begin
        fwd_inc = odd_rise; // R4
        rev_inc = even_rise; // R5
      end
      FPD_QUAD: begin
        fwd_inc = CE_I & tick & q_fwd; // R6
        rev_inc = CE_I & tick & q_rev; // R7
      end
    endcase
  end

  assign log_evt = CE_I && LOG_TICK_I;

  // Forward pulse counter, restarted at each log boundary
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      fwd_cnt_r <= '0;
    end else if (log_evt) begin
      fwd_cnt_r <= {{(CNT_W-1){1'b0}}, fwd_inc}; // R13
    end else if (CE_I && fwd_inc) begin
      fwd_cnt_r <= fwd_cnt_r + 1'b1; // R11
    end
  end

  // Reverse pulse counter, restarted at each log boundary
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rev_cnt_r <= '0;
    end else if (log_evt) begin
      rev_cnt_r <= {{(CNT_W-1){1'b0}}, rev_inc}; // R13
    end else if (CE_I && rev_inc) begin
      rev_cnt_r <= rev_cnt_r + 1'b1; // R11
    end
  end

  // Datapoint capture at each log boundary
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REC_VALID_O <= 1'b0;
      REC_INDEP_O <= 1'b0;
      REC_FWD_O <= '0;
      REC_REV_O <= '0;
      REC_NET_O <= '0;
    end else if (CE_I) begin
      REC_VALID_O <= LOG_TICK_I; // R13
      if (LOG_TICK_I) begin
        REC_INDEP_O <= indep; // R11 R12
        REC_FWD_O <= fwd_cnt_r; // R12 R14
        REC_REV_O <= indep ? rev_cnt_r : '0; // R12 R15
        REC_NET_O <= {1'b0, fwd_cnt_r} - {1'b0, rev_cnt_r}; // R22
      end
    end
  end

  // Pulse replication onto status outputs
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      STAT_OUT1_O <= 1'b0;
      STAT_OUT2_O <= 1'b0;
    end else if (CE_I) begin
      if (ctrl_r[CTRL_REPL_BIT]) begin
        STAT_OUT1_O <= (mode == FPD_UNI) ? (pin_sel ? even_lvl : odd_lvl) : odd_lvl; // R19 R20
        STAT_OUT2_O <= (mode == FPD_UNI) ? 1'b0 : even_lvl; // R20
      end else begin
        STAT_OUT1_O <= 1'b0;
        STAT_OUT2_O <= 1'b0;
      end
    end
  end

  // APB decode; single-cycle access phase
  assign addr_ok = (PADDR_I == ADDR_CTRL) || (PADDR_I == ADDR_STATUS) || (PADDR_I == ADDR_FWD) ||
                   (PADDR_I == ADDR_REV) || (PADDR_I == ADDR_NET) || (PADDR_I == ADDR_LIVE);
  assign wr_en = CE_I && PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = CE_I && PSEL_I && !PENABLE_I && !PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;

  // Control register write
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_en && (PADDR_I == ADDR_CTRL)) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Read data registered during setup, valid in the access phase
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (rd_en) begin
      unique case (PADDR_I)
        ADDR_CTRL: PRDATA_O <= {24'h000000, ctrl_r};
        ADDR_STATUS: PRDATA_O <= {28'h0000000, EVEN_CLAIMED_O, indep, even_lvl, odd_lvl};
        ADDR_FWD: PRDATA_O <= {16'h0000, REC_FWD_O};
        ADDR_REV: PRDATA_O <= {16'h0000, REC_REV_O};
        ADDR_NET: PRDATA_O <= {{15{REC_NET_O[NET_W-1]}}, REC_NET_O};
        ADDR_LIVE: PRDATA_O <= {rev_cnt_r, fwd_cnt_r};
        default: PRDATA_O <= 32'h00000000;
      endcase
    end
  end
endmodule : fpd_decoder
`default_nettype wire

// File: hw/fpd_pkg.sv
// Package: constants, register map and types of the flow pulse decoder
package fpd_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned HS_MIN_PULSE_MS = 16;
  localparam int unsigned PS_MIN_PULSE_MS = 500;
  // Sample every half of the shortest pulse so that any pulse gets at least one sample
  localparam int unsigned HS_TICK_CYC = (CLK_HZ / 1000) * HS_MIN_PULSE_MS / 2;
  localparam int unsigned PS_TICK_CYC = (CLK_HZ / 1000) * PS_MIN_PULSE_MS / 2;
  localparam int unsigned TICK_W = 24;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NET_W = 17;

  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FWD = 8'h08;
  localparam logic [7:0] ADDR_REV = 8'h0c;
  localparam logic [7:0] ADDR_NET = 8'h10;
  localparam logic [7:0] ADDR_LIVE = 8'h14;

  // CTRL field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_STORE_BIT = 2;
  localparam int unsigned CTRL_RATE_BIT = 3;
  localparam int unsigned CTRL_REPL_BIT = 4;
  localparam int unsigned CTRL_PIN_BIT = 5;
  localparam int unsigned CTRL_LOG_BIT = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Pin configuration of the input pair
  typedef enum logic [1:0] {
    FPD_UNI = 2'h0,
    FPD_PDIR = 2'h1,
    FPD_FWDREV = 2'h2,
    FPD_QUAD = 2'h3
  } fpd_mode_t;
endpackage : fpd_pkg

// File: hw/fpd_edge.sv
// Sampled input pin with open-to-closed edge detection
`timescale 1ns/100ps
`default_nettype none
module fpd_edge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Sample strobe and pin
  input wire logic tick_i,
  input wire logic pin_i,
  // Sampled level and edge pulse
  output logic level_o,
  output logic rise_o
);
  logic prev_r;

  // Take a sample on each tick; closed is high
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_r <= 1'b0;
    end else if (ce_i && tick_i) begin
      prev_r <= pin_i;
    end
  end

  assign level_o = prev_r;
  // Open to closed between two samples
  assign rise_o = ce_i & tick_i & pin_i & ~prev_r;
endmodule : fpd_edge
`default_nettype wire

// File: hw/fpd_tick.sv
// Global sample-rate strobe generator
`timescale 1ns/100ps
`default_nettype none
module fpd_tick #(
  parameter logic [23:0] HS_CYC = 24'h000001,
  parameter logic [23:0] PS_CYC = 24'h000001
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Rate select, high for power save
  input wire logic psave_i,
  // One-cycle sample strobe
  output logic tick_o
);
  logic [23:0] cnt_r;
  logic [23:0] lim;

  assign lim = psave_i ? PS_CYC : HS_CYC;
  assign tick_o = ce_i && (cnt_r >= lim - 24'h000001);

  // Free running divider
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 24'h000000;
    end else if (ce_i) begin
      cnt_r <= tick_o ? 24'h000000 : cnt_r + 24'h000001;
    end
  end
endmodule : fpd_tick
`default_nettype wire

// File: sim/fpd_decoder_properties.sv
// Port checker for the flow pulse decoder
`timescale 1ns/100ps
`default_nettype none
module fpd_decoder_chk (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic CE_I,
  input wire logic ARST_N_I,
  // APB and log strobe
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic LOG_TICK_I,
  // Records and status outputs
  input wire logic REC_VALID_O,
  input wire logic REC_INDEP_O,
  input wire logic [fpd_pkg::CNT_W-1:0] REC_FWD_O,
  input wire logic [fpd_pkg::CNT_W-1:0] REC_REV_O,
  input wire logic [fpd_pkg::NET_W-1:0] REC_NET_O,
  input wire logic STAT_OUT1_O,
  input wire logic STAT_OUT2_O,
  input wire logic EVEN_CLAIMED_O
);
  import fpd_pkg::*;
  logic [1:0] mode_r;
  logic indep_r;
  logic repl_r;
  logic ctl_wr;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // Control write as seen at the port
  assign ctl_wr = PSEL_I && PENABLE_I && PWRITE_I && CE_I && (PADDR_I == ADDR_CTRL);
  // Shadow of the control fields
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mode_r <= 2'h0;
      indep_r <= 1'b0;
      repl_r <= 1'b0;
    end else if (ctl_wr) begin
      mode_r <= PWDATA_I[1:0];
      indep_r <= PWDATA_I[2] && (PWDATA_I[1:0] == 2'h1);
      repl_r <= PWDATA_I[4];
    end
  end
  sequence s_ctl;
    ctl_wr;
  endsequence
  sequence s_rec;
    REC_VALID_O;
  endsequence
  // Record, claim and status output relations
  AST_CLAIM: assert property (s_ctl |=> EVEN_CLAIMED_O == ($past(PWDATA_I[1:0]) != 2'h0))
    else $error("even pin claim wrong");
  AST_QNET: assert property (REC_VALID_O && mode_r == 2'h3 |-> !REC_INDEP_O)
    else $error("quadrature record not net");
  AST_FRNET: assert property (REC_VALID_O && mode_r == 2'h2 |-> !REC_INDEP_O)
    else $error("fwd/rev record not net");
  AST_INDEP: assert property (REC_VALID_O && indep_r |-> REC_INDEP_O)
    else $error("independent record missing");
  AST_LOG: assert property (LOG_TICK_I && CE_I |=> s_rec)
    else $error("no record after log tick");
  AST_NOLOG: assert property (!(LOG_TICK_I && CE_I) |=> !REC_VALID_O)
    else $error("record without log tick");
  AST_REV0: assert property (REC_VALID_O && !REC_INDEP_O |-> REC_REV_O == '0)
    else $error("net record has reverse set");
  AST_NET: assert property (REC_VALID_O && REC_INDEP_O |-> REC_NET_O == ({1'b0, REC_FWD_O} - {1'b0, REC_REV_O}))
    else $error("net value not fwd minus rev");
  AST_UNI2: assert property (mode_r == 2'h0 && $past(mode_r) == 2'h0 |-> !STAT_OUT2_O)
    else $error("second output used in uni mode");
  AST_NOREP: assert property (!repl_r && !$past(repl_r) |-> !STAT_OUT1_O && !STAT_OUT2_O)
    else $error("replication while disabled");
endmodule : fpd_decoder_chk
`default_nettype wire

// File: sim/fpd_meter.sv
// Meter model stepping its pin pair through a fixed state list
`timescale 1ns/100ps
`default_nettype none
module fpd_meter #(
  parameter logic [9:0] SEQ = 10'h000,
  parameter int unsigned SLOT = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Meter pins, high is closed
  output logic odd_o,
  output logic even_o
);
  int unsigned cnt_r;
  int unsigned idx;
  // Cycle count from reset release
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  // States change midway between samples so each sample sees one state
  always_comb begin
    idx = (cnt_r + SLOT / 2) / SLOT;
    if (idx > 4) begin
      idx = 4;
    end
    {odd_o, even_o} = SEQ[2*idx +: 2];
  end
endmodule : fpd_meter
`default_nettype wire

// File: sim/fpd_decoder_bench.sv
// Testbench for the flow pulse decoder
`timescale 1ns/100ps
`default_nettype none
module fpd_decoder_bench;
  import fpd_pkg::*;
  // Shortened sample period so the pin test stays under a thousand cycles long
  localparam int unsigned BENCH_TICK = 200;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic log_tick = 1'b0;
  logic pin_odd, pin_even, pready, pslverr, rec_valid, rec_indep, stat1, stat2, claimed;
  logic [31:0] prdata;
  logic [NET_W-1:0] rec_net;
  logic [CNT_W-1:0] rec_fwd;
  logic [CNT_W-1:0] rec_rev;
  logic [33:0] q[$];
  logic [31:0] v;
  int failures = 0;
  int cmp_count = 0;
  int seed = 32'hcf69;
  fpd_decoder #(.HS_CYC(BENCH_TICK), .PS_CYC(BENCH_TICK * 4)) i_dut (.CLK_I(clk), .CE_I(1'b1),
    .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PIN_ODD_I(pin_odd), .PIN_EVEN_I(pin_even), .LOG_TICK_I(log_tick),
    .REC_VALID_O(rec_valid), .REC_INDEP_O(rec_indep), .REC_FWD_O(rec_fwd), .REC_REV_O(rec_rev),
    .REC_NET_O(rec_net),
    .STAT_OUT1_O(stat1), .STAT_OUT2_O(stat2), .EVEN_CLAIMED_O(claimed));
  // Quadrature meter: 00 01 11 10 forward, then back to 11
  fpd_meter #(.SEQ(10'b11_10_11_01_00), .SLOT(BENCH_TICK)) i_meter (.clk_i(clk), .arst_n_i(arst_n),
    .odd_o(pin_odd), .even_o(pin_even));
  task finish_test;
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [33:0] pop();
    return (q.size() > 0) ? q.pop_front() : 'x;
  endfunction : pop
  // APB transfer held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // One-cycle log period boundary
  task logt;
    log_tick <= 1'b1;
    @(posedge clk);
    log_tick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : logt
  // Clock generator
  initial begin
    forever #25 clk = ~clk;
  end
  // Result monitor: read data and records against oldest expectation
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) chk("apb read", {1'b0, pslverr, prdata}, pop());
    if (rec_valid) chk("record", {1'b1, rec_indep, 15'h0, rec_net}, pop());
  end
  // Watchdog beyond the four and a half sample periods of the pin test
  initial begin
    repeat (BENCH_TICK * 20) @(posedge clk);
    failures++;
    finish_test;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    q.push_back(34'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    for (int m = 0; m < 4; m++) begin
      v = ($random(seed) & 32'h30) | 32'h4 | 32'(m);
      apb(1'b1, ADDR_CTRL, v);
      chk("claim", {33'h0, claimed}, {33'h0, m != 0});
      q.push_back({2'b00, (m == 1) ? v : (v & ~32'h4)});
      apb(1'b0, ADDR_CTRL, 32'h0);
      q.push_back({1'b1, m == 1, 32'h0});
      logt;
    end
    q.push_back({2'b01, 32'h0});
    apb(1'b0, 8'h18, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h13);
    repeat (BENCH_TICK * 9 / 2) @(posedge clk);
    chk("replica", {32'h0, stat1, stat2}, 34'h3);
    q.push_back({2'b10, 15'h0, 17'h2});
    logt;
    chk("fwd count", {18'h0, rec_fwd}, 34'h3);
    chk("rev set", {18'h0, rec_rev}, 34'h0);
    finish_test;
  end
endmodule : fpd_decoder_bench
bind fpd_decoder fpd_decoder_chk i_chk (.CLK_I(CLK_I), .CE_I(CE_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .LOG_TICK_I(LOG_TICK_I),
  .REC_VALID_O(REC_VALID_O), .REC_INDEP_O(REC_INDEP_O), .REC_FWD_O(REC_FWD_O), .REC_REV_O(REC_REV_O),
  .REC_NET_O(REC_NET_O), .STAT_OUT1_O(STAT_OUT1_O), .STAT_OUT2_O(STAT_OUT2_O), .EVEN_CLAIMED_O(EVEN_CLAIMED_O));
`default_nettype wire
